//--- hdl/sps_pkg.sv
// constants and carrier types shared by the spi shift engine
// assumes a single system clock domain; all values are in clock cycles or bit positions
package sps_pkg;

   localparam int          SPS_BITS     = 8;

   // host clock sources and client modes in the mode field of control one
   localparam logic [3:0]  MODE_DIV4    = 4'h0;
   localparam logic [3:0]  MODE_DIV16   = 4'h1;
   localparam logic [3:0]  MODE_DIV64   = 4'h2;
   localparam logic [3:0]  MODE_TIMER   = 4'h3;
   localparam logic [3:0]  MODE_CLI_SS  = 4'h4;
   localparam logic [3:0]  MODE_CLI     = 4'h5;
   localparam logic [3:0]  MODE_DIVREG  = 4'ha;

   // half serial clock periods in system clocks: fosc/4, /16, /64
   localparam logic [9:0]  HALF_DIV4    = 10'h002;
   localparam logic [9:0]  HALF_DIV16   = 10'h008;
   localparam logic [9:0]  HALF_DIV64   = 10'h020;
   localparam logic [3:0]  LAST_EDGE    = 4'hf;
   localparam logic [3:0]  LAST_SAMPLE  = 4'h7;

   // status register layout
   localparam int          STAT_SMP_BIT = 7;
   localparam int          STAT_CKE_BIT = 6;
   localparam int          STAT_FULL_BIT = 0;

   localparam logic [7:0]  CTL_RESET    = 8'h00;
   localparam logic [1:0]  STAT_RESET   = 2'h0;
   localparam logic [7:0]  DIV_RESET    = 8'h00;
   localparam logic [7:0]  BUF_RESET    = 8'h00;

   typedef struct packed {
      logic       write_collision_flag;
      logic       ovf;
      logic       en;
      logic       ckp;
      logic [3:0] mode;
   } sps_ctl_t;

   typedef struct packed {
      logic smp;
      logic cke;
   } sps_stat_rw_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_HOST   = 2'b01,
      ST_CLIENT = 2'b10
   } sps_state_t;

endpackage

//--- hdl/sps_shifter.sv
// spi host/client shift engine with its data buffer, control and status registers
// assumes software strobes and pins are synchronous to ref_clk; pin tri-state is resolved outside
// Functional notes
// - one eight-bit shift register sends and collects each byte.
// - msb leaves first; received bit enters lsb on the same shift.
// - data changes on the configured edge, captured on the opposite edge.
// - host presents first bit with the clock; both sides share clock polarity.
// - every serial clock cycle sends one bit and captures one bit.
// - after eight shifts registers are swapped; next byte needs a reload.
// - host issues serial clocks in whole groups of eight unless disabled or switched out of a host mode mid-byte.
// - host with no more data stops the clock and releases client select.
// - unselected client ignores clock and data and never drives output.
// - host gives each client its own select, at most one active.
// - complete received byte goes to data buffer and sets done flag.
// - buffer write loads both data buffer and shift register.
// - shift register is reachable only through the data buffer.
// - status low six bits read-only, upper two bits read/write.
// - control one is fully read/write and holds the configuration.
// - five host clock modes, one uses the clock divider register.
// - port works as host driving the clock or as client.
// - buffer write during a transfer is dropped and sets write collision.
// - buffer full sets on receive and clears on buffer read.
// - host rate fosc/4, /16, /64, timer/2 or fosc/(4*(div+1)).
// - host starts the transfer as soon as the buffer is written.
`timescale 1ns/10ps
module sps_shifter
   import sps_pkg::*;
#(
   parameter int N_SEL = 4,
   parameter int SEL_W = 2
)(
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   input  wire logic               ctl_wr,
   input  wire sps_ctl_t           ctl_wdata,
   input  wire logic               stat_wr,
   input  wire logic [7:0]         stat_wdata,
   input  wire logic               div_wr,
   input  wire logic [7:0]         div_wdata,
   input  wire logic               buf_wr,
   input  wire logic [7:0]         buf_wdata,
   input  wire logic               buf_rd,
   input  wire logic               done_clear,
   input  wire logic               timer_tick,
   input  wire logic [SEL_W-1:0]   client_sel,
   input  wire logic               sck_in,
   input  wire logic               sdi,
   input  wire logic               ss_n_in,
   output sps_ctl_t                port_control_one,
   output logic [7:0]              port_status_reg,
   output logic [7:0]              clock_divider_reg,
   output logic [7:0]              data_buffer,
   output logic                    transfer_done_flag,
   output logic                    busy,
   output logic                    sck_out,
   output logic                    sck_oe,
   output logic                    sdo,
   output logic                    sdo_oe,
   output logic [N_SEL-1:0]        sel_n
);

   sps_state_t         state;
   sps_state_t         next_state;
   sps_ctl_t           ctl;
   sps_ctl_t           next_ctl;
   sps_stat_rw_t       stat_rw;
   sps_stat_rw_t       next_stat_rw;
   logic               buffer_full_flag;
   logic               next_buffer_full_flag;
   logic               done_q;
   logic               next_done_q;
   logic [7:0]         div_q;
   logic [7:0]         next_div_q;
   logic [7:0]         buf_q;
   logic [7:0]         next_buf_q;
   logic [7:0]         shift_reg;
   logic [7:0]         next_shift_reg;
   logic               sdo_q;
   logic               next_sdo_q;
   logic               sck_q;
   logic               next_sck_q;
   logic               sck_prev;
   logic [3:0]         bit_cnt;
   logic [3:0]         next_bit_cnt;
   logic [3:0]         hedge;
   logic [3:0]         next_hedge;
   logic [9:0]         half_cnt;
   logic [9:0]         next_half_cnt;
   logic [SEL_W-1:0]   sel_q;
   logic [SEL_W-1:0]   next_sel_q;

   logic               en;
   logic               host_mode;
   logic               client_mode;
   logic               ss_act;
   logic [9:0]         half_len;
   logic               tick;
   logic               edge_ev;
   logic               lead;
   logic               sample_ev;
   logic               out_ev;
   logic               done_ev;
   logic               in_progress;
   logic               wr_ok;
   logic               set_collision;
   logic               set_ovf;

   assign en          = ctl.en;
   assign host_mode   = ctl.mode inside {MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER,
                                         MODE_DIVREG};
   assign client_mode = (ctl.mode == MODE_CLI_SS) || (ctl.mode == MODE_CLI);
   assign ss_act      = (ctl.mode != MODE_CLI_SS) || !ss_n_in;
   assign in_progress = (state == ST_HOST) || (bit_cnt != 4'h0);
   assign wr_ok       = en && !in_progress && !ctl.write_collision_flag;

   // half period of the host serial clock
   always_comb
   begin
      unique case (ctl.mode)
         MODE_DIV16:  half_len = HALF_DIV16;
         MODE_DIV64:  half_len = HALF_DIV64;
         MODE_DIVREG: half_len = {1'b0, div_q, 1'b0} + 10'h002;
         default:     half_len = HALF_DIV4;
      endcase
   end

   assign tick = (ctl.mode == MODE_TIMER) ? timer_tick : (half_cnt == half_len - 10'h001);

   // serial edges: host from its own toggle, client from the pin
   always_comb
   begin
      if (state == ST_HOST)
      begin
         edge_ev = tick;
         lead    = !hedge[0];
      end
      else
      begin
         edge_ev = (state == ST_CLIENT) && ss_act && (sck_in != sck_prev);
         lead    = (sck_in != ctl.ckp);
      end
   end

   assign sample_ev = edge_ev && (lead == stat_rw.cke);
   assign out_ev    = edge_ev && (lead != stat_rw.cke);
   // no completion while disabled, so a frozen port never raises its flags
   assign done_ev   = en && ((state == ST_HOST) ? (tick && hedge == LAST_EDGE)
                                                : (sample_ev && bit_cnt == LAST_SAMPLE));

   always_comb
   begin
      next_state     = state;
      next_ctl       = ctl;
      next_stat_rw   = stat_rw;
      next_buffer_full_flag = buffer_full_flag;
      next_done_q    = done_q;
      next_div_q     = div_q;
      next_buf_q     = buf_q;
      next_shift_reg = shift_reg;
      next_sdo_q     = sdo_q;
      next_sck_q     = sck_q;
      next_bit_cnt   = bit_cnt;
      next_hedge     = hedge;
      next_half_cnt  = half_cnt;
      next_sel_q     = sel_q;
      set_collision  = 1'b0;
      set_ovf        = 1'b0;

      if (ctl_wr)
         next_ctl = ctl_wdata;
      if (stat_wr)
         next_stat_rw = sps_stat_rw_t'(stat_wdata[STAT_SMP_BIT:STAT_CKE_BIT]);
      if (div_wr)
         next_div_q = div_wdata;

      if (!en)
      begin
         // disabled: everything idle, flags untouched
         next_state    = ST_IDLE;
         next_bit_cnt  = 4'h0;
         next_hedge    = 4'h0;
         next_half_cnt = 10'h000;
         next_sck_q    = ctl.ckp;
         if (buf_wr)
         begin
            next_buf_q     = buf_wdata;
            next_shift_reg = buf_wdata;
            next_sdo_q     = buf_wdata[7];
         end
      end
      else
      begin
         if (state == ST_HOST)
         begin
            next_half_cnt = tick ? 10'h000 : half_cnt + 10'h001;
            if (tick)
            begin
               next_sck_q = !sck_q;
               next_hedge = hedge + 4'h1;
            end
         end
         if (sample_ev)
         begin
            next_shift_reg = {shift_reg[6:0], sdi};
            next_bit_cnt   = bit_cnt + 4'h1;
         end
         if (out_ev)
            next_sdo_q = shift_reg[7];
         if (state == ST_CLIENT && !ss_act)
            next_bit_cnt = 4'h0;
         if (done_ev)
         begin
            next_buf_q   = next_shift_reg;
            next_done_q  = 1'b1;
            next_buffer_full_flag = 1'b1;
            set_ovf      = buffer_full_flag && !buf_rd;
            next_bit_cnt = 4'h0;
            next_hedge   = 4'h0;
         end
         else if (buf_rd)
            next_buffer_full_flag = 1'b0;

         // leaving a role mid-byte drops the partial count, else busy would stick
         if (state == ST_HOST && (done_ev || !host_mode))
         begin
            next_state   = ST_IDLE;
            next_sck_q   = ctl.ckp;
            next_bit_cnt = 4'h0;
            next_hedge   = 4'h0;
         end
         else if (state == ST_CLIENT && !client_mode)
         begin
            next_state   = ST_IDLE;
            next_bit_cnt = 4'h0;
         end
         else if (state == ST_IDLE && client_mode)
            next_state = ST_CLIENT;
         else if (state == ST_IDLE)
            next_sck_q = ctl.ckp;

         if (buf_wr && wr_ok)
         begin
            next_buf_q     = buf_wdata;
            next_shift_reg = buf_wdata;
            next_sdo_q     = buf_wdata[7];
            if (host_mode)
            begin
               next_state    = ST_HOST;
               next_hedge    = 4'h0;
               next_half_cnt = 10'h000;
               next_sel_q    = client_sel;
            end
         end
         else if (buf_wr)
            set_collision = 1'b1;
      end

      if (done_clear && !done_ev)
         next_done_q = 1'b0;
      next_ctl.write_collision_flag = next_ctl.write_collision_flag || set_collision;
      next_ctl.ovf  = next_ctl.ovf || set_ovf;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state     <= ST_IDLE;
         ctl       <= sps_ctl_t'(CTL_RESET);
         stat_rw   <= sps_stat_rw_t'(STAT_RESET);
         buffer_full_flag <= 1'b0;
         done_q    <= 1'b0;
         div_q     <= DIV_RESET;
         buf_q     <= BUF_RESET;
         shift_reg <= BUF_RESET;
         sdo_q     <= 1'b0;
         sck_q     <= 1'b0;
         sck_prev  <= 1'b0;
         bit_cnt   <= 4'h0;
         hedge     <= 4'h0;
         half_cnt  <= 10'h000;
         sel_q     <= '0;
      end
      else
      begin
         state     <= next_state;
         ctl       <= next_ctl;
         stat_rw   <= next_stat_rw;
         buffer_full_flag <= next_buffer_full_flag;
         done_q    <= next_done_q;
         div_q     <= next_div_q;
         buf_q     <= next_buf_q;
         shift_reg <= next_shift_reg;
         sdo_q     <= next_sdo_q;
         sck_q     <= next_sck_q;
         sck_prev  <= sck_in;
         bit_cnt   <= next_bit_cnt;
         hedge     <= next_hedge;
         half_cnt  <= next_half_cnt;
         sel_q     <= next_sel_q;
      end
   end

   // one active-low select per client, only the latched one during a transfer
   genvar gi;
   generate
      for (gi = 0; gi < N_SEL; gi++)
      begin : g_sel
         assign sel_n[gi] = !((state == ST_HOST) && (sel_q == SEL_W'(gi)));
      end
   endgenerate

   assign port_control_one   = ctl;
   assign port_status_reg    = {stat_rw.smp, stat_rw.cke, 5'h00, buffer_full_flag};
   assign clock_divider_reg  = div_q;
   assign data_buffer        = buf_q;
   assign transfer_done_flag = done_q;
   assign busy               = in_progress;
   assign sck_out            = sck_q;
   assign sck_oe             = en && host_mode;
   assign sdo                = sdo_q;
   assign sdo_oe             = en && (host_mode || (client_mode && ss_act));

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_write_accepted;
      buf_wr && wr_ok;
   endsequence

   sequence s_host_mid_div4;
      state == ST_HOST && ctl.mode == MODE_DIV4 && half_cnt == 10'h000 && hedge != 4'h0
         && en && !ctl_wr ##1 !ctl_wr;
   endsequence

   chk_done_sets_flags: assert property (done_ev |=>
      buffer_full_flag && transfer_done_flag)
      else $error("received byte did not set buffer full and done");
   chk_write_loads_both: assert property (s_write_accepted |=>
      data_buffer == $past(buf_wdata) && sdo == $past(buf_wdata[7]))
      else $error("buffer write did not load buffer and shifter");
   chk_collision_drop: assert property (buf_wr && en && in_progress
      && !done_ev |=> ctl.write_collision_flag && data_buffer == $past(data_buffer))
      else $error("write during transfer not dropped");
   chk_read_clears_full: assert property (buf_rd && en && !done_ev |=>
      !buffer_full_flag)
      else $error("buffer read did not clear buffer full");
   chk_status_low_ro: assert property (stat_wr && !done_ev && !buf_rd |=>
      port_status_reg[5:0] == $past(port_status_reg[5:0]))
      else $error("status write changed read-only bits");
   chk_host_start: assert property (s_write_accepted ##0 host_mode |=>
      state == ST_HOST)
      else $error("host did not start on buffer write");
   chk_div4_rate: assert property (s_host_mid_div4 |-> tick)
      else $error("fosc/4 half period is not two clocks");
   chk_whole_byte: assert property ($fell(state == ST_HOST)
      && $past(en && host_mode) |-> $past(hedge) == LAST_EDGE)
      else $error("host stopped inside a byte");
   chk_sel_onehot: assert property ($onehot0(~sel_n))
      else $error("more than one client selected");
   chk_client_quiet: assert property (ctl.mode == MODE_CLI_SS && ss_n_in |->
      !sdo_oe)
      else $error("unselected client drives data");
   chk_disabled_idle: assert property (!en |=> state == ST_IDLE
      && bit_cnt == 4'h0 && $stable(buffer_full_flag)
      && ($stable(transfer_done_flag) || $past(done_clear)))
      else $error("disabled port not idle");
   chk_idle_release: assert property (state == ST_IDLE && $past(state) == ST_IDLE
      && $stable(ctl.ckp) && en |-> sck_out == ctl.ckp && &sel_n)
      else $error("idle host clock or select not released");

endmodule

//--- sim/sps_client_model.sv
// behavioural spi client standing on the host pins of the shift engine
// assumes sck idles at ckp between frames and cke matches the engine setting
`timescale 1ns/10ps
module sps_client_model
(
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic       ckp,
   input  wire logic       cke,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      sr
);
   // select as it stood before this time step, so the final edge still counts
   logic sel_seen = 1'b1;
   always @(sel_n) sel_seen <= sel_n;
   initial miso = 1'b0;
   // byte loaded on select; msb ready before the first edge when cke is set
   always @(negedge sel_n)
   begin
      sr = tx_byte;
      if (cke)
         miso = tx_byte[7];
   end
   // a released line shows the inverse of its last value
   always @(posedge sel_n) miso = ~miso;
   always @(sck)
   begin
      if (!sel_seen)
      begin
         if ((sck != ckp) == cke)
            sr = {sr[6:0], mosi};
         else
            miso = sr[7];
      end
   end
endmodule

//--- sim/spi_host_client_shifter_tb.sv
// self-checking bench for the spi shift engine in host, client and disabled states
// assumes one 200 MHz clock and a behavioural client on the host pins
`timescale 1ns/10ps
module spi_host_client_shifter_tb;
   import sps_pkg::*;
   localparam int LIMIT = 30000;
   logic       ref_clk, nrst, timer_tick, sck_in, ss_n_in, cl_sdi, host_phase;
   logic [5:0] stb;
   logic [7:0] wd, port_status_reg, clock_divider_reg, data_buffer, cl_tx, cl_rx;
   logic [1:0] client_sel;
   logic [3:0] sel_n;
   logic [3:0] modes [0:5];
   logic       transfer_done_flag, busy, sck_out, sck_oe, sdo, sdo_oe, miso;
   sps_ctl_t   port_control_one;
   wire logic  sdi = host_phase ? miso : cl_sdi;
   int         miscompares, checked, cyc;
   integer     seed;

   sps_shifter uut (.ref_clk(ref_clk), .nrst(nrst), .ctl_wr(stb[0]),
      .ctl_wdata(sps_ctl_t'(wd)), .stat_wr(stb[1]), .stat_wdata(wd), .div_wr(stb[2]),
      .div_wdata(wd), .buf_wr(stb[3]), .buf_wdata(wd), .buf_rd(stb[4]),
      .done_clear(stb[5]), .timer_tick(timer_tick), .client_sel(client_sel),
      .sck_in(sck_in), .sdi(sdi), .ss_n_in(ss_n_in), .port_control_one(port_control_one),
      .port_status_reg(port_status_reg), .clock_divider_reg(clock_divider_reg),
      .data_buffer(data_buffer), .transfer_done_flag(transfer_done_flag), .busy(busy),
      .sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo), .sdo_oe(sdo_oe), .sel_n(sel_n));

   sps_client_model partner (.sck(sck_out), .mosi(sdo), .sel_n(sel_n[client_sel]),
      .ckp(port_control_one.ckp), .cke(port_status_reg[STAT_CKE_BIT]),
      .tx_byte(cl_tx), .miso(miso), .sr(cl_rx));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      timer_tick <= (cyc % 3 == 0);
      if (cyc == LIMIT)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // strobe index: 0 control, 1 status, 2 divider, 3 buffer write, 4 buffer read, 5 done clear
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge ref_clk);
      wd <= d;
      stb <= 6'h01 << k;
      @(posedge ref_clk);
      stb <= 6'h00;
   endtask

   function automatic int half_of(input logic [3:0] m, input logic [7:0] d);
      case (m)
         MODE_DIV4:  return 2;
         MODE_DIV16: return 8;
         MODE_DIV64: return 32;
         default:    return 2 * (d + 1);
      endcase
   endfunction

   task automatic host_xfer(input logic [3:0] m, input logic [7:0] d, input logic coll);
      int         n;
      int         tg;
      logic       last;
      logic       ck;
      logic [3:0] es;
      logic [7:0] tx;
      logic [7:0] sw;
      tx = $random(seed);
      sw = $random(seed);
      ck = $random(seed);
      cl_tx = $random(seed);
      @(posedge ref_clk);
      client_sel <= $random(seed);
      wr(2, d);
      wr(1, sw);
      wr(0, {3'h1, ck, m});
      @(negedge ref_clk);
      check(clock_divider_reg, d);
      check(port_status_reg[7:1], {sw[7:6], 5'h00});
      check(port_control_one, {3'h1, ck, m});
      wr(3, tx);
      if (coll)
         fork
            begin
               repeat (4) @(posedge ref_clk);
               wd <= ~tx;
               stb <= 6'h08;
               @(posedge ref_clk);
               stb <= 6'h00;
            end
         join_none
      @(negedge ref_clk);
      es = ~(4'h1 << client_sel);
      check(busy, 1'b1);
      check(sel_n, es);
      check(sdo, tx[7]);
      n = 1;
      tg = 0;
      last = sck_out;
      while (busy === 1'b1 && n < 20000)
      begin
         @(negedge ref_clk);
         n += (busy === 1'b1);
         tg += (sck_out !== last);
         last = sck_out;
      end
      check(tg, 16);
      if (m != MODE_TIMER)
         check(n, 16 * half_of(m, d));
      check(data_buffer, cl_tx);
      check(cl_rx, tx);
      check({port_status_reg[0], transfer_done_flag}, 2'h3);
      check({sel_n, sck_out}, {4'hf, ck});
      check(port_control_one.write_collision_flag, coll);
      if (coll)
      begin
         wr(3, tx);
         @(negedge ref_clk);
         check({busy, data_buffer}, {1'b0, cl_tx});
         wr(0, {3'h1, ck, m});
      end
      wr(4, 8'h00);
      wr(5, 8'h00);
      @(negedge ref_clk);
      check({port_status_reg[0], transfer_done_flag}, 2'h0);
   endtask

   task automatic client_xfer(input logic [3:0] m);
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] got;
      tx = $random(seed);
      rx = $random(seed);
      host_phase = 1'b0;
      wr(1, 8'h40);
      wr(0, {3'h1, 1'b0, m});
      wr(3, tx);
      if (m == MODE_CLI_SS)
      begin
         repeat (4)
         begin
            @(posedge ref_clk);
            sck_in <= ~sck_in;
            repeat (3) @(posedge ref_clk);
         end
         @(negedge ref_clk);
         check({busy, sdo_oe, sck_oe}, 3'h0);
         @(posedge ref_clk);
         ss_n_in <= 1'b0;
         @(negedge ref_clk);
         check(sdo_oe, 1'b1);
      end
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge ref_clk);
         cl_sdi <= rx[i];
         repeat (6) @(negedge ref_clk);
         got[i] = sdo;
         @(posedge ref_clk);
         sck_in <= 1'b1;
         repeat (6) @(posedge ref_clk);
         sck_in <= 1'b0;
      end
      repeat (6) @(negedge ref_clk);
      check({data_buffer, got}, {rx, tx});
      check(transfer_done_flag, 1'b1);
      @(posedge ref_clk);
      ss_n_in <= 1'b1;
      wr(4, 8'h00);
      wr(5, 8'h00);
   endtask

   initial
   begin
      logic [7:0] r;
      seed = 32'h9e33e712;
      nrst = 1'b0;
      stb = 6'h00;
      wd = 8'h00;
      timer_tick = 1'b0;
      client_sel = 2'h0;
      sck_in = 1'b0;
      ss_n_in = 1'b1;
      cl_sdi = 1'b0;
      host_phase = 1'b1;
      cl_tx = 8'h00;
      cyc = 0;
      miscompares = 0;
      checked = 0;
      modes = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER, MODE_DIVREG, MODE_DIVREG};
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      check({port_control_one, port_status_reg, clock_divider_reg, data_buffer}, 32'h0);
      check({transfer_done_flag, busy, sck_oe, sdo_oe, sel_n}, 8'h0f);
      wr(3, 8'h5a);
      @(negedge ref_clk);
      check({data_buffer, busy, transfer_done_flag, sck_oe}, {8'h5a, 3'h0});
      repeat (4)
      begin
         r = $random(seed) & 8'hdf;
         wr(0, r);
         @(negedge ref_clk);
         check(port_control_one, r);
      end
      foreach (modes[i])
         host_xfer(modes[i], (i == 4) ? 8'hff : (i == 5) ? 8'h00 : 8'($random(seed) & 7),
            i[0]);
      client_xfer(MODE_CLI_SS);
      client_xfer(MODE_CLI);
      wr(0, 8'h00);
      wr(3, 8'hc3);
      @(negedge ref_clk);
      check({data_buffer, busy, sck_oe, sel_n}, {8'hc3, 2'h0, 4'hf});
      conclude();
   end
endmodule
